// *** prw_walker.v ***
// Product record walker: reads the header and packet chain of the product
// record from a serial memory over I2C and hands each packet data byte out.
// Assumes a 250 MHz clock, synchronous reset, open-drain pins resolved outside.
//
// Function
// R1 - Serial memory is two independent 256-byte regions: product and presence records.
// R2 - Product region at target address a0, presence region at a8.
// R3 - Product record is a header (marker, size) followed by contiguous packets.
// R4 - Marker must match before any packet is trusted; else uninitialized.
// R5 - Size field is total bytes assigned to the product region.
// R6 - Packet is identifier, then length, then that many data bytes.
// R7 - Next packet address is data base plus length.
// R8 - Packets accepted in any order, no fixed position per identifier.
// R9 - Walk ends on the terminating identifier right after the last packet.
// R10 - Optional checksum packet may be used to check record integrity.
// R11 - Same identifier may carry differing lengths; no fixed length assumed.
// R12 - User-range packets are passed through with the same length chaining.
// R13 - Identifier and length are one byte each, data follows at once.
// R14 - Error stop if packet address reaches size or region end unterminated.
`timescale 1ns/10ps
`default_nettype none
`include "prw_defs.vh"
module prw_walker #(
    parameter QTR_CYC = `PRW_QTR_CYC,
    parameter [31:0] MARKER = `PRW_MARK_DEF
) (
    input wire clk,
    input wire rst_n,
    input wire go,
    input wire sda_in,
    output reg scl_oe,
    output reg sda_oe,
    output reg busy,
    output reg done,
    output reg uninit,
    output reg walk_err,
    output reg bus_err,
    output reg sum_bad,
    output reg pkt_valid,
    output reg [7:0] pkt_id,
    output reg [7:0] pkt_len,
    output reg [7:0] pkt_idx,
    output reg [7:0] pkt_data,
    output reg pkt_user
);
    localparam W_IDLE = 3'd0;
    localparam W_HDR = 3'd1;
    localparam W_ID = 3'd2;
    localparam W_LEN = 3'd3;
    localparam W_DATA = 3'd4;
    localparam W_WAIT = 3'd5;

    wire tick;
    wire rd_done;
    wire rd_nack;
    wire [7:0] rd_data;
    wire rd_scl_oe;
    wire rd_sda_oe;
    reg rd_start_q;
    reg [2:0] st_q;
    reg [2:0] ret_q;
    reg [8:0] addr_q;
    reg [31:0] mark_q;
    reg [15:0] size_q;
    reg [7:0] id_q;
    reg [7:0] len_q;
    reg [7:0] cnt_q;
    reg [7:0] sum_q;
    reg [8:0] limit_d;

    prw_tick #(.DIV(QTR_CYC)) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // Only the product region is walked; offset is the low byte (see R1) (see R2)
    prw_i2c_byte u_rd (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .start(rd_start_q),
        .dev_addr(`PRW_ADDR_PRODUCT),
        .offset(addr_q[7:0]),
        .busy(),
        .done(rd_done),
        .nack(rd_nack),
        .rdata(rd_data),
        .scl_oe(rd_scl_oe),
        .sda_oe(rd_sda_oe),
        .sda_in(sda_in)
    );

    // Walk limit: the smaller of the size field and the region end (see R5) (see R14)
    always @*
    begin
        if (size_q < {7'h00, `PRW_REGION_BYTES})
            limit_d = size_q[8:0];
        else
            limit_d = `PRW_REGION_BYTES;
    end

    // Pins re-registered so every output is a flip-flop
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            scl_oe <= rd_scl_oe;
            sda_oe <= rd_sda_oe;
        end
    end

    // Walk sequencer: one random read per byte, trading speed for simplicity
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= W_IDLE;
            ret_q <= W_IDLE;
            rd_start_q <= 1'b0;
            addr_q <= 9'h000;
            mark_q <= 32'h00000000;
            size_q <= 16'h0000;
            id_q <= 8'h00;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            sum_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            uninit <= 1'b0;
            walk_err <= 1'b0;
            bus_err <= 1'b0;
            sum_bad <= 1'b0;
            pkt_valid <= 1'b0;
            pkt_id <= 8'h00;
            pkt_len <= 8'h00;
            pkt_idx <= 8'h00;
            pkt_data <= 8'h00;
            pkt_user <= 1'b0;
        end
        else
        begin
            rd_start_q <= 1'b0;
            pkt_valid <= 1'b0;
            done <= 1'b0;
            case (st_q)
                W_IDLE:
                begin
                    if (go)
                    begin
                        busy <= 1'b1;
                        uninit <= 1'b0;
                        walk_err <= 1'b0;
                        bus_err <= 1'b0;
                        sum_bad <= 1'b0;
                        sum_q <= 8'h00;
                        addr_q <= 9'h000;
                        rd_start_q <= 1'b1;
                        st_q <= W_WAIT;
                        ret_q <= W_HDR;
                    end
                end
                W_WAIT:
                begin
                    if (rd_done)
                    begin
                        if (rd_nack)
                        begin
                            bus_err <= 1'b1;
                            busy <= 1'b0;
                            done <= 1'b1;
                            st_q <= W_IDLE;
                        end
                        else
                            st_q <= ret_q;
                    end
                end
                W_HDR:
                begin
                    // Header: marker bytes then big-endian size (see R3)
                    if (addr_q < {1'b0, `PRW_MARK_LEN})
                        mark_q <= {mark_q[23:0], rd_data};
                    else
                        size_q <= {size_q[7:0], rd_data};
                    if (addr_q == {1'b0, `PRW_HDR_LEN} - 9'h001)
                    begin
                        if (mark_q != MARKER)
                        begin
                            // No packet is trusted without a valid marker (see R4)
                            uninit <= 1'b1;
                            busy <= 1'b0;
                            done <= 1'b1;
                            st_q <= W_IDLE;
                        end
                        else
                        begin
                            addr_q <= {1'b0, `PRW_HDR_LEN};
                            rd_start_q <= 1'b1;
                            st_q <= W_WAIT;
                            ret_q <= W_ID;
                        end
                    end
                    else
                    begin
                        addr_q <= addr_q + 9'h001;
                        rd_start_q <= 1'b1;
                        st_q <= W_WAIT;
                    end
                end
                W_ID:
                begin
                    // Identifier byte, whatever its position (see R8) (see R13)
                    id_q <= rd_data;
                    if (rd_data == `PRW_ID_END)
                    begin
                        // Terminator ends the walk; checksum result stands (see R9)
                        busy <= 1'b0;
                        done <= 1'b1;
                        st_q <= W_IDLE;
                    end
                    else if (addr_q + 9'h001 >= limit_d)
                    begin
                        walk_err <= 1'b1; // see R14
                        busy <= 1'b0;
                        done <= 1'b1;
                        st_q <= W_IDLE;
                    end
                    else
                    begin
                        sum_q <= sum_q + rd_data;
                        addr_q <= addr_q + 9'h001;
                        rd_start_q <= 1'b1;
                        st_q <= W_WAIT;
                        ret_q <= W_LEN;
                    end
                end
                W_LEN:
                begin
                    // Length taken per packet, never per identifier (see R6) (see R11)
                    len_q <= rd_data;
                    cnt_q <= 8'h00;
                    if (id_q != `PRW_ID_CHECK)
                        sum_q <= sum_q + rd_data;
                    if (addr_q + 9'h001 + {1'b0, rd_data} >= limit_d)
                    begin
                        walk_err <= 1'b1; // see R14
                        busy <= 1'b0;
                        done <= 1'b1;
                        st_q <= W_IDLE;
                    end
                    else if (rd_data == 8'h00)
                    begin
                        // Empty data section: next packet directly follows (see R7)
                        addr_q <= addr_q + 9'h001;
                        rd_start_q <= 1'b1;
                        st_q <= W_WAIT;
                        ret_q <= W_ID;
                    end
                    else
                    begin
                        addr_q <= addr_q + 9'h001;
                        rd_start_q <= 1'b1;
                        st_q <= W_WAIT;
                        ret_q <= W_DATA;
                    end
                end
                W_DATA:
                begin
                    // Every data byte, user range included, is handed out; zero-length packets give none (see R12)
                    pkt_valid <= 1'b1;
                    pkt_id <= id_q;
                    pkt_len <= len_q;
                    pkt_idx <= cnt_q;
                    pkt_data <= rd_data;
                    pkt_user <= (id_q >= `PRW_ID_USER_LO);
                    if (id_q == `PRW_ID_CHECK)
                    begin
                        // First data byte holds the sum of prior packet bytes plus its own identifier (see R10)
                        if (cnt_q == 8'h00 && rd_data != sum_q)
                            sum_bad <= 1'b1;
                    end
                    else
                        sum_q <= sum_q + rd_data;
                    cnt_q <= cnt_q + 8'h01;
                    // Data base plus length chains to the next packet (see R7)
                    addr_q <= addr_q + 9'h001;
                    rd_start_q <= 1'b1;
                    st_q <= W_WAIT;
                    if (cnt_q == len_q - 8'h01)
                        ret_q <= W_ID;
                end
                default:
                begin
                    st_q <= W_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** prw_defs.vh ***
// Constants for the product record walker: bus addresses, header layout, timing.
// Assumes inclusion by bare name from the walker and its helpers.
`ifndef PRW_DEFS_VH
`define PRW_DEFS_VH
// Target addresses of the two 256-byte regions (8-bit form, R/W bit zero)
`define PRW_ADDR_PRODUCT 8'ha0
`define PRW_ADDR_PRESENCE 8'ha8
// Header layout: marker bytes, then a two-byte size, big-endian
`define PRW_MARK_LEN 8'h04
`define PRW_SIZE_POS 8'h04
`define PRW_HDR_LEN 8'h06
// Default marker value, arbitrary
`define PRW_MARK_DEF 32'h50524543
// Identifier values
`define PRW_ID_END 8'hff
`define PRW_ID_CHECK 8'h01
`define PRW_ID_USER_LO 8'hc0
// Region size in bytes
`define PRW_REGION_BYTES 9'h100
// SCL timing: quarter period in ns and in 250 MHz cycles
`define PRW_CLK_NS 4
`define PRW_QTR_NS 2500
`define PRW_QTR_CYC ((`PRW_QTR_NS + `PRW_CLK_NS - 1) / `PRW_CLK_NS)
`endif

// *** prw_tick.v ***
// Divider: one-cycle enable pulse every DIV clocks, for the I2C bit phases.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module prw_tick #(
    parameter DIV = 625
) (
    input wire clk,
    input wire rst_n,
    output reg tick
);
    reg [15:0] cnt_q;

    // Free-running count, pulse on wrap
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt_q == DIV[15:0] - 16'h0001)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** prw_i2c_byte.v ***
// I2C random-read engine: one byte from a 256-byte region at a given offset.
// Assumes open-drain pins resolved outside; SCL stretching is not supported.
`timescale 1ns/10ps
`default_nettype none
`include "prw_defs.vh"
module prw_i2c_byte (
    input wire clk,
    input wire rst_n,
    input wire tick,
    input wire start,
    input wire [7:0] dev_addr,
    input wire [7:0] offset,
    output reg busy,
    output reg done,
    output reg nack,
    output reg [7:0] rdata,
    output reg scl_oe,
    output reg sda_oe,
    input wire sda_in
);
    // Sequence steps; each bit uses four quarter phases
    localparam S_IDLE = 3'd0;
    localparam S_START = 3'd1;
    localparam S_BYTE = 3'd2;
    localparam S_RSTART = 3'd3;
    localparam S_STOP = 3'd4;

    reg [2:0] st_q;
    reg [1:0] ph_q;
    reg [3:0] bit_q;
    reg [1:0] byte_q;
    reg [7:0] sh_q;
    reg [7:0] off_q;
    reg [7:0] dev_q;
    reg fail_q;

    wire [7:0] next_tx;
    // Byte order: write address, offset, read address, data
    assign next_tx = (byte_q == 2'd0) ? dev_q :
                     (byte_q == 2'd1) ? off_q : (dev_q | 8'h01);

    // Bit engine: SCL low in phases 0,3, high in 1,2; sample in phase 2
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= S_IDLE;
            ph_q <= 2'd0;
            bit_q <= 4'h0;
            byte_q <= 2'd0;
            sh_q <= 8'h00;
            off_q <= 8'h00;
            dev_q <= 8'h00;
            fail_q <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            rdata <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (st_q == S_IDLE)
            begin
                if (start)
                begin
                    st_q <= S_START;
                    dev_q <= dev_addr;
                    off_q <= offset;
                    byte_q <= 2'd0;
                    ph_q <= 2'd0;
                    fail_q <= 1'b0;
                    busy <= 1'b1;
                end
            end
            else if (tick)
            begin
                ph_q <= ph_q + 2'd1;
                case (st_q)
                    S_START, S_RSTART:
                    begin
                        // SDA released, SCL high, then SDA falls while SCL high
                        if (ph_q == 2'd0)
                        begin
                            sda_oe <= 1'b0;
                        end
                        else if (ph_q == 2'd1)
                        begin
                            scl_oe <= 1'b0;
                        end
                        else if (ph_q == 2'd2)
                        begin
                            sda_oe <= 1'b1;
                        end
                        else
                        begin
                            scl_oe <= 1'b1;
                            st_q <= S_BYTE;
                            bit_q <= 4'h0;
                            sh_q <= next_tx;
                        end
                    end
                    S_BYTE:
                    begin
                        if (ph_q == 2'd0)
                        begin
                            // Data byte reads freely; master acks nothing (NACK on bit 8)
                            if (bit_q == 4'h8)
                                sda_oe <= 1'b0;
                            else if (byte_q == 2'd3)
                                sda_oe <= 1'b0;
                            else
                                sda_oe <= ~sh_q[7];
                        end
                        else if (ph_q == 2'd1)
                        begin
                            scl_oe <= 1'b0;
                        end
                        else if (ph_q == 2'd2)
                        begin
                            if (bit_q == 4'h8)
                            begin
                                if (byte_q != 2'd3 && sda_in)
                                    fail_q <= 1'b1;
                            end
                            else
                                sh_q <= {sh_q[6:0], sda_in};
                        end
                        else
                        begin
                            scl_oe <= 1'b1;
                            if (bit_q == 4'h8)
                            begin
                                bit_q <= 4'h0;
                                byte_q <= byte_q + 2'd1;
                                if (fail_q || byte_q == 2'd3)
                                    st_q <= S_STOP;
                                else if (byte_q == 2'd1)
                                    st_q <= S_RSTART;
                                else
                                    sh_q <= off_q; // Offset follows the write address
                                if (byte_q == 2'd3)
                                    rdata <= sh_q;
                            end
                            else
                                bit_q <= bit_q + 4'h1;
                        end
                    end
                    S_STOP:
                    begin
                        // SDA low, SCL high, then SDA rises while SCL high
                        if (ph_q == 2'd0)
                        begin
                            sda_oe <= 1'b1;
                        end
                        else if (ph_q == 2'd1)
                        begin
                            scl_oe <= 1'b0;
                        end
                        else if (ph_q == 2'd2)
                        begin
                            sda_oe <= 1'b0;
                        end
                        else
                        begin
                            st_q <= S_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                            nack <= fail_q;
                        end
                    end
                    default:
                    begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** prw_eeprom.sv ***
// Serial memory model: one 256-byte region answering random reads.
// Assumes pull-ups on both lines; the master makes every clock edge.
`timescale 1ns/10ps
`default_nettype none
module prw_eeprom #(
    parameter [6:0] DEV = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_en,
    output logic sda_oe
);
    logic [7:0] mem [0:255];
    logic [7:0] sh, ptr, dat, dev_seen;
    int bc = 0;
    int st = 0;
    initial
        sda_oe = 1'b0;
    // Start or repeated start restarts framing; a stop goes idle
    always @(negedge sda)
    begin
        if (scl === 1'b1)
        begin
            st = 1;
            bc = -1;
        end
    end
    always @(posedge sda)
    begin
        if (scl === 1'b1)
            st = 0;
    end
    // Bits are taken while the clock is high
    always @(posedge scl)
    begin
        if (st != 0 && bc < 8)
            sh = {sh[6:0], sda};
        else if (st == 3 && bc == 8 && sda === 1'b1)
            st = 0; // NACK ends the read, line left free
    end
    // Drive only on the falling clock so no false start or stop appears
    always @(negedge scl)
    begin
        if (st != 0)
        begin
            bc = (bc == 8) ? 0 : bc + 1;
            sda_oe = 1'b0;
            if (bc == 8 && st == 1)
            begin
                dev_seen = sh;
                sda_oe = (sh[7:1] == DEV) && !nack_en;
                st = sda_oe ? (sh[0] ? 3 : 2) : 0;
            end
            else if (bc == 8 && st == 2)
            begin
                ptr = sh;
                sda_oe = 1'b1;
            end
            else if (st == 3 && bc < 8)
            begin
                if (bc == 0)
                begin
                    dat = mem[ptr];
                    ptr = ptr + 8'h01;
                end
                sda_oe = ~dat[7 - bc];
            end
        end
    end
endmodule
`default_nettype wire

// *** prw_monitor.sv ***
// Checker on the walker's ports.
// Assumes a bind from the bench; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module prw_monitor #(
    parameter QTR_CYC = 2,
    parameter [31:0] MARKER = 32'h50524543
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic busy,
    input wire logic done,
    input wire logic uninit,
    input wire logic walk_err,
    input wire logic bus_err,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_id,
    input wire logic [7:0] pkt_len,
    input wire logic [7:0] pkt_idx,
    input wire logic pkt_user
);
    logic [7:0] lid_q, llen_q, lidx_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Last byte handed out, so the next can be tied to it
    always_ff @(posedge clk)
    begin
        if (pkt_valid)
        begin
            lid_q <= pkt_id;
            llen_q <= pkt_len;
            lidx_q <= pkt_idx;
        end
    end
    // One byte read takes about 320 cycles
    sequence s_next_byte;
        ##[1:400] pkt_valid;
    endsequence
    a_done_pulse: assert property (done |=> !done)
        else $error("done held");
    a_done_busy: assert property (done |-> busy || $past(busy))
        else $error("done without walk");
    a_go_taken: assert property (go && !busy |=> busy)
        else $error("go not taken");
    a_idle_quiet: assert property (!busy |-> !scl_oe && !sda_oe && !pkt_valid)
        else $error("activity while idle");
    a_scl_hold: assert property (busy && $changed(scl_oe) |=> $stable(scl_oe))
        else $error("clock pin too short");
    a_pkt_user: assert property (pkt_valid |-> pkt_user == (pkt_id >= 8'hc0))
        else $error("user flag wrong");
    a_pkt_range: assert property (pkt_valid |-> pkt_idx < pkt_len && pkt_id != 8'hff)
        else $error("byte outside packet");
    a_pkt_chain: assert property (pkt_valid && pkt_idx != 8'h00 |->
        pkt_id == lid_q && pkt_len == llen_q && pkt_idx == lidx_q + 8'h01)
        else $error("packet bytes out of step");
    a_pkt_next: assert property (pkt_valid && pkt_idx + 8'h01 < pkt_len |-> s_next_byte)
        else $error("packet cut short");
    a_end_onehot: assert property (done |-> $onehot0({uninit, walk_err, bus_err}))
        else $error("several end causes");
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Random and corner-case bench for the walker against a memory model.
// Assumes the walker, its helpers, the model and the checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "prw_defs.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic nack_en = 1'b0;
    logic sda_in, scl_w, scl_oe, sda_oe, mem_oe, busy, done;
    logic uninit, walk_err, bus_err, sum_bad, pkt_valid, pkt_user;
    logic [7:0] pkt_id, pkt_len, pkt_idx, pkt_data, sum, rid, rlen;
    logic [31:0] expq [$];
    int err_total = 0, cmp_count = 0, wp;
    int seed = 32'hbc35;
    bit chk_on = 1'b0;
    // Open-drain lines with pull-ups: low while any party drives
    assign scl_w = ~scl_oe;
    assign sda_in = ~(sda_oe | mem_oe);
    always #2 clk = ~clk;
    prw_walker #(.QTR_CYC(2)) u_prw_walker (.clk(clk), .rst_n(rst_n), .go(go),
        .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .busy(busy), .done(done),
        .uninit(uninit), .walk_err(walk_err), .bus_err(bus_err), .sum_bad(sum_bad),
        .pkt_valid(pkt_valid), .pkt_id(pkt_id), .pkt_len(pkt_len), .pkt_idx(pkt_idx),
        .pkt_data(pkt_data), .pkt_user(pkt_user));
    prw_eeprom u_prw_eeprom (.scl(scl_w), .sda(sda_in), .nack_en(nack_en), .sda_oe(mem_oe));
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_pkt(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected packet at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [32:0] exp_pkt(input logic [31:0] e);
        return {e, e[31:24] >= `PRW_ID_USER_LO};
    endfunction
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Each handed-out byte must be the next one laid into memory
    always @(posedge clk)
    begin
        #1;
        if (pkt_valid === 1'b1 && chk_on)
            chk_pkt({pkt_id, pkt_len, pkt_idx, pkt_data, pkt_user},
                expq.size() != 0 ? exp_pkt(expq.pop_front()) : 33'h1ffffffff);
    end
    task automatic put(input logic [7:0] b);
        u_prw_eeprom.mem[wp[7:0]] = b;
        wp++;
    endtask
    // Fill with noise so stale bytes never look like a valid chain
    task automatic new_rec(input logic [31:0] mark, input logic [15:0] size);
        for (int i = 0; i < 256; i++)
            u_prw_eeprom.mem[i] = 8'($random(seed));
        expq.delete();
        wp = 0;
        sum = 8'h00;
        for (int i = 3; i >= 0; i--)
            put(mark[i * 8 +: 8]);
        put(size[15:8]);
        put(size[7:0]);
    endtask
    task automatic add_pkt(input logic [7:0] id, input logic [7:0] len);
        logic [7:0] d;
        put(id);
        put(len);
        sum = sum + id + len;
        for (int i = 0; i < len; i++)
        begin
            d = 8'($random(seed));
            put(d);
            sum = sum + d;
            expq.push_back({id, len, i[7:0], d});
        end
    endtask
    task automatic add_sum(input logic [7:0] flip);
        logic [7:0] d;
        d = (sum + `PRW_ID_CHECK) ^ flip;
        put(`PRW_ID_CHECK);
        put(8'h01);
        put(d);
        expq.push_back({16'h0101, 8'h00, d});
        put(`PRW_ID_END);
    endtask
    // A second go in mid-walk must be ignored
    task automatic run_walk(input logic [3:0] exp, input bit twice, input bit chk);
        int n;
        chk_on = chk;
        for (n = 0; n < 60000 && done !== 1'b1; n++)
        begin
            @(posedge clk);
            #1 go = (n == 0) || (twice && n == 300);
        end
        if (n >= 60000)
        begin
            err_total++;
            $display("unexpected hang at %0t: got %h exp %h", $time, done, 1'b1);
            end_sim();
        end
        else
        begin
            repeat (2) @(posedge clk);
            #1 chk_byte({4'h0, uninit, walk_err, bus_err, sum_bad}, {4'h0, exp});
            if (chk)
                chk_byte(8'(expq.size()), 8'h00);
            $display("walk ended at %0t, mismatches %0d", $time, err_total);
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            new_rec(`PRW_MARK_DEF, 16'h0100);
            for (int p = 0; p < 2 + r; p++)
            begin
                rid = 8'h02 + 8'($unsigned($random(seed)) % 253);
                rlen = 8'($unsigned($random(seed)) % 5);
                add_pkt(rid, rlen);
            end
            put(`PRW_ID_END);
            run_walk(4'h0, r == 1, 1'b1);
        end
        new_rec(`PRW_MARK_DEF, 16'h0100);
        add_pkt(8'h05, 8'h03);
        add_pkt(8'hc0, 8'h00);
        add_pkt(8'h05, 8'h01);
        add_pkt(8'hfe, 8'h02);
        add_sum(8'h00);
        run_walk(4'h0, 1'b0, 1'b1);
        chk_byte(u_prw_eeprom.dev_seen, 8'ha1);
        new_rec(`PRW_MARK_DEF, 16'h0100);
        add_pkt(8'h10, 8'h02);
        add_sum(8'h5a);
        run_walk(4'h1, 1'b0, 1'b1);
        new_rec(`PRW_MARK_DEF ^ 32'h00000100, 16'h0100);
        put(`PRW_ID_END);
        run_walk(4'h8, 1'b0, 1'b1);
        new_rec(`PRW_MARK_DEF, 16'h0008);
        add_pkt(8'h02, 8'h03);
        put(`PRW_ID_END);
        run_walk(4'h4, 1'b0, 1'b0);
        nack_en = 1'b1;
        new_rec(`PRW_MARK_DEF, 16'h0100);
        run_walk(4'h2, 1'b0, 1'b1);
        nack_en = 1'b0;
        add_pkt(8'h20, 8'h01);
        put(`PRW_ID_END);
        run_walk(4'h0, 1'b0, 1'b1);
        end_sim();
    end
endmodule
bind prw_walker prw_monitor #(.QTR_CYC(QTR_CYC), .MARKER(MARKER)) u_prw_monitor (
    .clk(clk), .rst_n(rst_n), .go(go), .scl_oe(scl_oe), .sda_oe(sda_oe), .busy(busy),
    .done(done), .uninit(uninit), .walk_err(walk_err), .bus_err(bus_err),
    .pkt_valid(pkt_valid), .pkt_id(pkt_id), .pkt_len(pkt_len), .pkt_idx(pkt_idx),
    .pkt_user(pkt_user));
`default_nettype wire
